// file: testbench/boot_checker_properties.sv
// Concurrent checks on the boot clock and boot source selector ports
`timescale 1ns/1ps
module boot_checker #(
	parameter int RESET_WAIT_CLOCKS = 20
)(
	input wire logic        i_mclk,
	input wire logic        i_rst,
	input wire logic        i_oscillator_source_strap,
	input wire logic [7:0]  i_security_bits,
	input wire logic        i_pll_cfg_we,
	input wire logic [2:0]  i_pll_cfg_od,
	input wire logic [11:0] i_pll_cfg_f,
	input wire logic [5:0]  i_pll_cfg_r,
	input wire logic [1:0]  i_link_rx,
	input wire logic        o_osc_external,
	input wire logic        o_analog_clk_external,
	input wire logic [2:0]  o_pll_output_divider,
	input wire logic [11:0] o_pll_feedback,
	input wire logic [5:0]  o_pll_input_divider,
	input wire logic [12:0] o_ratio_num,
	input wire logic [11:0] o_ratio_den,
	input wire logic        o_pll_clk_routed,
	input wire logic [7:0]  o_ref_clk_divider,
	input wire logic        o_gpio_pull_en,
	input wire logic        o_boot_from_otp,
	input wire logic        o_jtag_wait,
	input wire logic        o_spi_pins_en,
	input wire logic        o_spi_sclk,
	input wire logic        o_spi_ss_n,
	input wire logic        o_link_en,
	input wire logic        o_link_pulldown_en,
	input wire logic [1:0]  o_link_tx,
	input wire logic [1:0]  o_link_tx_oe,
	input wire logic        o_link_traffic
);
	int          since_r;   // Cycles since reset release, saturating
	int          since_nxt; // Next value of the cycle counter
	logic [11:0] den_exp;   // Expected ratio denominator
	assign den_exp = 12'(2 * (int'(o_pll_input_divider) + 1)
		* (int'(o_pll_output_divider) + 1));
	// Counter stops just past the wait so it never wraps
	always_comb begin
		since_nxt = (since_r < RESET_WAIT_CLOCKS + 8) ? since_r + 1 : since_r;
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			since_r <= 0;
		else
			since_r <= since_nxt;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	a_pins_float_reset: assert property ($fell(i_rst) |-> !o_gpio_pull_en
		&& !o_spi_pins_en && o_link_tx_oe == 2'h0 && o_spi_ss_n)
		else $error("pins driven right after reset");
	a_osc_source_pick: assert property (o_pll_clk_routed |->
		o_osc_external == (i_oscillator_source_strap ==
		clock_boot_pkg::OSC_STRAP_EXTERNAL)
		&& o_analog_clk_external == o_osc_external)
		else $error("oscillator choice wrong");
	a_ratio_num_val: assert property (o_pll_clk_routed |->
		o_ratio_num == {1'b0, o_pll_feedback} + 13'h0001)
		else $error("ratio numerator wrong");
	a_ratio_den_val: assert property (o_pll_clk_routed |->
		o_ratio_den == den_exp)
		else $error("ratio denominator wrong");
	a_cfg_write_taken: assert property (i_pll_cfg_we && o_pll_clk_routed
		|=> {o_pll_output_divider, o_pll_feedback, o_pll_input_divider} ==
		$past({i_pll_cfg_od, i_pll_cfg_f, i_pll_cfg_r}))
		else $error("pll write not applied");
	a_ref_div_fixed: assert property (o_ref_clk_divider == 8'h04)
		else $error("reference divider wrong");
	a_pull_en_time: assert property ($rose(o_gpio_pull_en) |->
		since_r >= RESET_WAIT_CLOCKS - 1 && since_r <= RESET_WAIT_CLOCKS + 1)
		else $error("pull enable at wrong time");
	a_link_pins_on: assert property ($rose(o_link_en) |->
		!o_link_pulldown_en && o_link_tx_oe == 2'h3 && o_link_tx == 2'h0)
		else $error("link pins wrong on enable");
	a_traffic_cause: assert property ($rose(o_link_traffic) |->
		$past(i_link_rx) != 2'h0 ##1 o_link_traffic)
		else $error("traffic flag without cause");
	a_sclk_half_rate: assert property ($rose(o_spi_sclk) |->
		!o_spi_ss_n && o_spi_pins_en ##2 !o_spi_sclk)
		else $error("flash clock rate wrong");
	a_otp_overrides: assert property (o_boot_from_otp |->
		i_security_bits[5] && !o_spi_pins_en && !o_link_en && !o_jtag_wait)
		else $error("otp boot not exclusive");
endmodule
bind clock_pll_and_boot_select boot_checker #(
	.RESET_WAIT_CLOCKS(RESET_WAIT_CLOCKS)) boot_checker_i (.*);

// file: testbench/spi_flash_model.sv
// Serial boot flash: takes a 32-bit command, then streams data bytes
`timescale 1ns/1ps
module spi_flash_model (
	input  wire logic  i_sclk,
	input  wire logic  i_ss_n,
	input  wire logic  i_mosi,
	output logic       o_miso,
	output logic [31:0] o_cmd
);
	int count; // Rising clock edges in this frame
	// Data byte n is 0x96 + 17*n, bit index counted MSB first
	function automatic logic data_bit(input int n);
		logic [7:0] d;
		d = 8'h96 + 8'(17 * (n / 8));
		return d[7 - n % 8];
	endfunction
	initial begin
		o_miso = 1'b0;
		o_cmd  = 32'h0000_0000;
	end
	// Command bits sampled on the rising clock edge
	always @(posedge i_sclk or posedge i_ss_n) begin
		if (i_ss_n) begin
			count <= 0;
		end else begin
			if (count < 32)
				o_cmd <= {o_cmd[30:0], i_mosi};
			count <= count + 1;
		end
	end
	// Data changes on the falling edge; undriven line flips level
	always @(negedge i_sclk or posedge i_ss_n) begin
		if (i_ss_n || count < 32)
			o_miso <= ~o_miso;
		else
			o_miso <= data_bit(count - 32);
	end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the boot clock and boot source selector
`timescale 1ns/1ps
module testbench;
	localparam int WAIT = 20; // Shortened internal reset
	logic        i_mclk, i_rst, i_oscillator_source_strap;
	logic        i_pll_ratio_strap_lo, i_pll_ratio_strap_hi;
	logic [1:0]  i_boot_source_strap, i_link_rx;
	logic [7:0]  i_security_bits, o_ref_clk_divider, o_boot_byte;
	logic        i_pll_cfg_we, i_spi_miso, i_boot_done;
	logic [2:0]  i_pll_cfg_od, o_pll_output_divider;
	logic [11:0] i_pll_cfg_f, o_pll_feedback, o_ratio_den;
	logic [5:0]  i_pll_cfg_r, o_pll_input_divider;
	logic        o_osc_external, o_analog_clk_external, o_pll_clk_routed;
	logic        o_gpio_pull_en, o_boot_from_otp, o_jtag_wait;
	logic        o_spi_pins_en, o_spi_sclk, o_spi_mosi, o_spi_ss_n;
	logic        o_boot_byte_valid, o_link_en, o_link_pulldown_en;
	logic        o_link_traffic;
	logic [12:0] o_ratio_num;
	logic [1:0]  o_link_tx, o_link_tx_oe;
	logic [31:0] flash_cmd;
	int          mismatches, num_checks, n, nb;
	// Default settings per ratio strap code {hi, lo}
	logic [2:0]  od_t [4] = '{3'h1, 3'h2, 3'h2, 3'h2};
	logic [11:0] f_t [4]  = '{12'h07a, 12'h017, 12'h031, 12'h077};
	clock_pll_and_boot_select #(.RESET_WAIT_CLOCKS(WAIT))
		clock_pll_and_boot_select_i (.*);
	spi_flash_model spi_flash_model_i (.i_sclk(o_spi_sclk),
		.i_ss_n(o_spi_ss_n), .i_mosi(o_spi_mosi), .o_miso(i_spi_miso),
		.o_cmd(flash_cmd));
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] act, exp, input string what);
		num_checks++;
		if (act !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s %h not %h", $time, what, act, exp);
		end
	endtask
	// Bounded wait ran out: count it and close the run
	task automatic limit(input int k, lim);
		if (k >= lim) begin
			mismatches++;
			$display("unexpected at %0t: wait ran out", $time);
			print_verdict();
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask
	// Reset with given straps, try an early write, check capture
	task automatic start(input logic osc, input logic [1:0] code, boot,
		input logic [7:0] sec);
		@(posedge i_mclk);
		i_rst <= 1'b1;
		i_oscillator_source_strap <= osc;
		{i_pll_ratio_strap_hi, i_pll_ratio_strap_lo} <= code;
		i_boot_source_strap <= boot;
		i_security_bits <= sec;
		repeat (16) @(posedge i_mclk);
		check(o_gpio_pull_en, 1'b0, "pull in reset");
		check({o_spi_pins_en, o_link_tx_oe}, 3'h0, "pin oe");
		check({o_spi_ss_n, o_link_pulldown_en}, 2'h3, "idle pins");
		i_rst <= 1'b0;
		{i_pll_cfg_we, i_pll_cfg_od, i_pll_cfg_f} <= {1'b1, 3'h7, 12'h0fff};
		i_pll_cfg_r <= 6'h3f;
		@(posedge i_mclk);
		i_pll_cfg_we <= 1'b0;
		cyc(3);
		check(o_pll_clk_routed, 1'b1, "routed");
		check({o_osc_external, o_analog_clk_external}, {2{~osc}}, "osc");
		check(o_pll_output_divider, od_t[code], "od");
		check(o_pll_feedback, f_t[code], "f");
		check(o_pll_input_divider, 6'h00, "r");
		check(o_ratio_num, 13'(f_t[code]) + 13'h0001, "num");
		check(o_ratio_den, 12'(2 * (od_t[code] + 1)), "den");
		check(o_ref_clk_divider, 8'h04, "ref div");
		for (n = 4; n < WAIT + 12 && o_gpio_pull_en !== 1'b1; n++)
			cyc(1);
		limit(n, WAIT + 12);
		check(n >= WAIT - 1 && n <= WAIT + 2, 1'b1, "pull time");
	endtask
	// Follow the chosen boot path to its visible effect
	task automatic boot_path(input logic [1:0] b);
		case (b)
			2'h0: begin
				for (n = 0; n < 8 && o_jtag_wait !== 1'b1; n++)
					cyc(1);
				limit(n, 8);
			end
			2'h1: begin
				cyc(8);
				check({o_jtag_wait, o_link_en, o_spi_pins_en, o_boot_from_otp},
					4'h0, "reserved");
			end
			2'h2: begin
				for (n = 0; n < 8 && o_link_en !== 1'b1; n++)
					cyc(1);
				limit(n, 8);
				check({o_link_tx_oe, o_link_tx}, 4'hc, "link tx");
				check({o_link_pulldown_en, o_link_traffic}, 2'h0, "link");
				@(posedge i_mclk);
				i_link_rx <= 2'h2;
				@(posedge i_mclk);
				i_link_rx <= 2'h0;
				cyc(3);
				check(o_link_traffic, 1'b1, "traffic");
			end
			default: begin
				nb = 0;
				for (n = 0; n < 900 && nb < 2; n++) begin
					cyc(1);
					if (o_boot_byte_valid === 1'b1) begin
						check(o_boot_byte, 8'h96 + 8'(17 * nb), "byte");
						nb++;
					end
				end
				limit(n, 900);
				check(flash_cmd, clock_boot_pkg::SPI_READ_FRAME, "cmd");
				@(posedge i_mclk);
				i_boot_done <= 1'b1;
				@(posedge i_mclk);
				i_boot_done <= 1'b0;
				cyc(3);
				check({o_spi_ss_n, o_spi_pins_en, o_spi_sclk}, 3'h4, "end");
			end
		endcase
	endtask
	initial begin
		{i_rst, i_oscillator_source_strap, i_pll_cfg_we, i_boot_done} = 4'h8;
		{i_pll_ratio_strap_hi, i_pll_ratio_strap_lo} = 2'h0;
		{i_boot_source_strap, i_link_rx, i_security_bits} = 12'h000;
		{i_pll_cfg_od, i_pll_cfg_f, i_pll_cfg_r} = 21'h00_0000;
		for (int i = 0; i < 4; i++) begin
			start(i[0], 2'(i), 2'(i), 8'h00);
			boot_path(2'(i));
		end
		// Security bit over a flash strap, then run-time writes
		start(1'b1, 2'h3, 2'h3, 8'h20);
		cyc(4);
		check({o_boot_from_otp, o_spi_pins_en}, 2'h2, "otp");
		@(posedge i_mclk);
		{i_pll_cfg_we, i_pll_cfg_od, i_pll_cfg_f} <= {1'b1, 3'h5, 12'h0c7};
		i_pll_cfg_r <= 6'h03;
		@(posedge i_mclk);
		// Second write: 500 MHz tile from the 20 MHz internal oscillator
		{i_pll_cfg_od, i_pll_cfg_f} <= {3'h0, 12'h031};
		i_pll_cfg_r <= 6'h00;
		#1;
		check({o_pll_output_divider, o_pll_feedback}, 15'h50c7, "w1");
		check({o_ratio_num, o_ratio_den}, {13'h00c8, 12'h030}, "w1 r");
		@(posedge i_mclk);
		i_pll_cfg_we <= 1'b0;
		#1;
		check({o_pll_output_divider, o_pll_input_divider}, 9'h000, "w2");
		check({o_ratio_num, o_ratio_den}, {13'h0032, 12'h002}, "w2 r");
		check(o_pll_feedback, 12'h031, "w2 f");
		print_verdict();
	end
endmodule

// file: verilog/clock_boot_pkg.sv
// Constants and types for the boot clock and boot source selector
package clock_boot_pkg;
	// System clock of this block
	localparam int CLK_PERIOD_NS = 100;

	// On-chip oscillator, used when the source strap is left open
	localparam int OSC_INTERNAL_MHZ = 20;
	localparam logic OSC_STRAP_EXTERNAL = 1'h0;

	// Ratio strap codes, {hi, lo}
	localparam logic [1:0] RATIO_5_13   = 2'h0;
	localparam logic [1:0] RATIO_13_20  = 2'h3;
	localparam logic [1:0] RATIO_20_48  = 2'h2;
	localparam logic [1:0] RATIO_48_100 = 2'h1;

	// Default output divider per strap code
	localparam logic [2:0] OD_5_13   = 3'h1;
	localparam logic [2:0] OD_13_20  = 3'h2;
	localparam logic [2:0] OD_20_48  = 3'h2;
	localparam logic [2:0] OD_48_100 = 3'h2;

	// Default feedback value per strap code
	localparam logic [11:0] FB_5_13   = 12'h07a;
	localparam logic [11:0] FB_13_20  = 12'h077;
	localparam logic [11:0] FB_20_48  = 12'h031;
	localparam logic [11:0] FB_48_100 = 12'h017;

	// Default input divider for every strap code
	localparam logic [5:0] IN_DIV_DEFAULT = 6'h00;

	// Ratio arithmetic: (F+1)/2 /(R+1) /(OD+1)
	localparam logic [12:0] FB_OFFSET  = 13'h0001;
	localparam logic [6:0]  IN_OFFSET  = 7'h01;
	localparam logic [3:0]  OD_OFFSET  = 4'h1;
	localparam logic [11:0] HALF_DENOM = 12'h002;

	// Straps are captured on this rising edge after reset release
	localparam int STRAP_EDGE = 3;
	localparam logic [1:0] STRAP_CAPTURE_CNT = 2'(STRAP_EDGE - 1);

	// Reference clock: 100 MHz from a 400 MHz tile clock, 10 ns tick
	localparam int REF_CLK_MHZ    = 100;
	localparam int TILE_BOOT_MHZ  = 400;
	localparam int TIMER_TICK_NS  = 1000 / REF_CLK_MHZ;
	localparam logic [7:0] REF_DIV_DEFAULT =
		8'(TILE_BOOT_MHZ / REF_CLK_MHZ);

	// Internal reset length in input clocks
	localparam int RESET_WAIT_DEFAULT = 750000;

	// Link enable delay after boot start, least time rounded up
	localparam int LINK_DELAY_NS  = 200;
	localparam int LINK_DELAY_CYC =
		(LINK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Serial flash clock 2.5 MHz, half period in system clocks
	localparam int SCLK_PERIOD_NS = 400;
	localparam int SCLK_HALF_RAW  = (SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
	localparam int SCLK_HALF_CYC  = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;

	// Flash read command followed by a zero address
	localparam logic [31:0] SPI_READ_FRAME = 32'h0300_0000;
	localparam logic [5:0]  SPI_CMD_LAST   = 6'h1f;
	localparam logic [2:0]  SPI_BYTE_LAST  = 3'h7;

	// Boot source strap codes
	localparam logic [1:0] BOOT_JTAG     = 2'h0;
	localparam logic [1:0] BOOT_RESERVED = 2'h1;
	localparam logic [1:0] BOOT_LINK     = 2'h2;
	localparam logic [1:0] BOOT_SPI      = 2'h3;

	// Security bit that forces boot from one-time memory
	localparam int SECURE_BOOT_BIT = 5;

	// Boot sequencer states
	typedef enum logic [3:0] {
		ST_RESET_WAIT,
		ST_SELECT,
		ST_OTP,
		ST_JTAG,
		ST_IDLE,
		ST_LINK_WAIT,
		ST_LINK,
		ST_SPI,
		ST_DONE
	} boot_state_type;
endpackage

// file: verilog/clock_pll_and_boot_select.sv
// Boot clock setup, internal reset timing and boot source sequencing
`timescale 1ns/1ps
// Functional notes
// - Source strap low picks external resonator
// - Ratio straps load default PLL divider values
// - Tile ratio is (F+1)/2/(R+1)/(OD+1)
// - Configuration write overrides all PLL fields
// - PLL output feeds switch, tile, reference
// - Reference clock defaults to 100 MHz
// - Analog node runs straight from oscillator
// - In reset all general pins float; the link pulldown stays on
// - After long internal reset, enable pulls, boot
// - Boot straps choose JTAG, link or flash
// - Security bit five forces boot from OTP
// - Flash boot: master on four pins, 2.5 MHz
// - Link boot: enable link, tx low, watch rx
module clock_pll_and_boot_select #(
	parameter int RESET_WAIT_CLOCKS = clock_boot_pkg::RESET_WAIT_DEFAULT,
	parameter int WAIT_CNT_W        = 20
)(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_oscillator_source_strap,
	input  wire logic        i_pll_ratio_strap_lo,
	input  wire logic        i_pll_ratio_strap_hi,
	input  wire logic [1:0]  i_boot_source_strap,
	input  wire logic [7:0]  i_security_bits,
	input  wire logic        i_pll_cfg_we,
	input  wire logic [2:0]  i_pll_cfg_od,
	input  wire logic [11:0] i_pll_cfg_f,
	input  wire logic [5:0]  i_pll_cfg_r,
	input  wire logic        i_spi_miso,
	input  wire logic        i_boot_done,
	input  wire logic [1:0]  i_link_rx,
	output logic             o_osc_external,
	output logic             o_analog_clk_external,
	output logic [2:0]       o_pll_output_divider,
	output logic [11:0]      o_pll_feedback,
	output logic [5:0]       o_pll_input_divider,
	output logic [12:0]      o_ratio_num,
	output logic [11:0]      o_ratio_den,
	output logic             o_pll_clk_routed,
	output logic [7:0]       o_ref_clk_divider,
	output logic             o_gpio_pull_en,
	output logic             o_boot_from_otp,
	output logic             o_jtag_wait,
	output logic             o_spi_pins_en,
	output logic             o_spi_sclk,
	output logic             o_spi_mosi,
	output logic             o_spi_ss_n,
	output logic [7:0]       o_boot_byte,
	output logic             o_boot_byte_valid,
	output logic             o_link_en,
	output logic             o_link_pulldown_en,
	output logic [1:0]       o_link_tx,
	output logic [1:0]       o_link_tx_oe,
	output logic             o_link_traffic
);
	// Strap capture and PLL configuration state
	logic [1:0]  edge_cnt_r;      // Edges seen since reset release
	logic [1:0]  edge_cnt_nxt;
	logic [1:0]  boot_src_r;      // Captured boot source straps
	logic [1:0]  boot_src_nxt;
	logic        osc_ext_nxt;
	logic [2:0]  od_nxt;
	logic [11:0] fb_nxt;
	logic [5:0]  in_div_nxt;
	logic [12:0] num_nxt;
	logic [11:0] den_nxt;
	logic        routed_nxt;
	logic [6:0]  in_p1;           // Input divider plus one
	logic [3:0]  od_p1;           // Output divider plus one

	// Sequencer state
	clock_boot_pkg::boot_state_type state_r;
	clock_boot_pkg::boot_state_type state_nxt;
	logic [WAIT_CNT_W-1:0] wait_cnt_r;  // Reset and link delay count
	logic [WAIT_CNT_W-1:0] wait_cnt_nxt;
	logic        pull_nxt;
	logic        otp_nxt;
	logic        jtag_nxt;
	logic        link_en_nxt;
	logic        pd_nxt;
	logic [1:0]  tx_oe_nxt;
	logic        traffic_nxt;

	// Serial flash engine state
	logic        spi_tick;        // Half-period tick from the divider
	logic        spi_run;
	logic [31:0] sh_out_r;        // Command and address shifter
	logic [31:0] sh_out_nxt;
	logic [7:0]  sh_in_r;         // Incoming byte shifter
	logic [7:0]  sh_in_nxt;
	logic [5:0]  bit_cnt_r;       // Bits in current command or byte
	logic [5:0]  bit_cnt_nxt;
	logic        cmd_phase_r;     // Still sending the read command
	logic        cmd_phase_nxt;
	logic        sclk_nxt;
	logic        mosi_nxt;
	logic        ss_n_nxt;
	logic        pins_nxt;
	logic [7:0]  byte_nxt;
	logic        byte_valid_nxt;

	// Strap capture on the third edge, PLL defaults and overrides
	always_comb begin
		edge_cnt_nxt = edge_cnt_r;
		boot_src_nxt = boot_src_r;
		osc_ext_nxt  = o_osc_external;
		od_nxt       = o_pll_output_divider;
		fb_nxt       = o_pll_feedback;
		in_div_nxt   = o_pll_input_divider;
		routed_nxt   = o_pll_clk_routed;
		if (edge_cnt_r != clock_boot_pkg::STRAP_CAPTURE_CNT + 2'h1) begin
			edge_cnt_nxt = edge_cnt_r + 2'h1;
		end
		if (edge_cnt_r == clock_boot_pkg::STRAP_CAPTURE_CNT) begin
			boot_src_nxt = i_boot_source_strap;
			// Grounded strap selects the external resonator
			osc_ext_nxt  = (i_oscillator_source_strap ==
				clock_boot_pkg::OSC_STRAP_EXTERNAL);
			in_div_nxt   = clock_boot_pkg::IN_DIV_DEFAULT;
			unique case ({i_pll_ratio_strap_hi, i_pll_ratio_strap_lo})
				clock_boot_pkg::RATIO_5_13: begin
					od_nxt = clock_boot_pkg::OD_5_13;
					fb_nxt = clock_boot_pkg::FB_5_13;
				end
				clock_boot_pkg::RATIO_13_20: begin
					od_nxt = clock_boot_pkg::OD_13_20;
					fb_nxt = clock_boot_pkg::FB_13_20;
				end
				clock_boot_pkg::RATIO_20_48: begin
					od_nxt = clock_boot_pkg::OD_20_48;
					fb_nxt = clock_boot_pkg::FB_20_48;
				end
				clock_boot_pkg::RATIO_48_100: begin
					od_nxt = clock_boot_pkg::OD_48_100;
					fb_nxt = clock_boot_pkg::FB_48_100;
				end
			endcase
			// Switch, tile and reference now run from the PLL
			routed_nxt = 1'b1;
		end else if (i_pll_cfg_we && o_pll_clk_routed) begin
			// Run-time ratio change, range kept by software
			od_nxt     = i_pll_cfg_od;
			fb_nxt     = i_pll_cfg_f;
			in_div_nxt = i_pll_cfg_r;
		end
		// Ratio numerator and denominator of the tile clock
		in_p1   = {1'b0, in_div_nxt} + clock_boot_pkg::IN_OFFSET;
		od_p1   = {1'b0, od_nxt} + clock_boot_pkg::OD_OFFSET;
		num_nxt = {1'b0, fb_nxt} + clock_boot_pkg::FB_OFFSET;
		den_nxt = 12'(in_p1) * 12'(od_p1) *
			clock_boot_pkg::HALF_DENOM;
	end

	// Register strap and PLL state
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			edge_cnt_r            <= 2'h0;
			boot_src_r            <= clock_boot_pkg::BOOT_JTAG;
			o_osc_external        <= 1'b0;
			o_analog_clk_external <= 1'b0;
			o_pll_output_divider  <= clock_boot_pkg::OD_5_13;
			o_pll_feedback        <= clock_boot_pkg::FB_5_13;
			o_pll_input_divider   <= clock_boot_pkg::IN_DIV_DEFAULT;
			o_ratio_num           <= 13'h0000;
			o_ratio_den           <= 12'h000;
			o_pll_clk_routed      <= 1'b0;
			o_ref_clk_divider     <= clock_boot_pkg::REF_DIV_DEFAULT;
		end else begin
			edge_cnt_r            <= edge_cnt_nxt;
			boot_src_r            <= boot_src_nxt;
			o_osc_external        <= osc_ext_nxt;
			// Analog node follows the oscillator, no PLL
			o_analog_clk_external <= osc_ext_nxt;
			o_pll_output_divider  <= od_nxt;
			o_pll_feedback        <= fb_nxt;
			o_pll_input_divider   <= in_div_nxt;
			o_ratio_num           <= num_nxt;
			o_ratio_den           <= den_nxt;
			o_pll_clk_routed      <= routed_nxt;
			// Fixed divide for a 100 MHz reference, 10 ns tick
			o_ref_clk_divider     <= clock_boot_pkg::REF_DIV_DEFAULT;
		end
	end

	// Boot sequencer: internal reset, source choice, link bring-up
	always_comb begin
		state_nxt    = state_r;
		wait_cnt_nxt = wait_cnt_r;
		pull_nxt     = o_gpio_pull_en;
		otp_nxt      = o_boot_from_otp;
		jtag_nxt     = o_jtag_wait;
		link_en_nxt  = o_link_en;
		pd_nxt       = o_link_pulldown_en;
		tx_oe_nxt    = o_link_tx_oe;
		traffic_nxt  = o_link_traffic;
		unique case (state_r)
			clock_boot_pkg::ST_RESET_WAIT: begin
				// Pins stay floating until the count runs out
				if (wait_cnt_r == WAIT_CNT_W'(RESET_WAIT_CLOCKS - 1)) begin
					pull_nxt     = 1'b1;
					wait_cnt_nxt = '0;
					state_nxt    = clock_boot_pkg::ST_SELECT;
				end else begin
					wait_cnt_nxt = wait_cnt_r + WAIT_CNT_W'(1);
				end
			end
			clock_boot_pkg::ST_SELECT: begin
				// Security bit overrides the straps
				if (i_security_bits[clock_boot_pkg::SECURE_BOOT_BIT]) begin
					otp_nxt   = 1'b1;
					state_nxt = clock_boot_pkg::ST_OTP;
				end else begin
					unique case (boot_src_r)
						clock_boot_pkg::BOOT_JTAG: begin
							jtag_nxt  = 1'b1;
							state_nxt = clock_boot_pkg::ST_JTAG;
						end
						clock_boot_pkg::BOOT_RESERVED: begin
							state_nxt = clock_boot_pkg::ST_IDLE;
						end
						clock_boot_pkg::BOOT_LINK: begin
							state_nxt = clock_boot_pkg::ST_LINK_WAIT;
						end
						clock_boot_pkg::BOOT_SPI: begin
							state_nxt = clock_boot_pkg::ST_SPI;
						end
					endcase
				end
			end
			clock_boot_pkg::ST_LINK_WAIT: begin
				// Short delay before the link comes up
				if (wait_cnt_r ==
					WAIT_CNT_W'(clock_boot_pkg::LINK_DELAY_CYC - 1)) begin
					link_en_nxt = 1'b1;
					pd_nxt      = 1'b0;
					tx_oe_nxt   = 2'h3;
					state_nxt   = clock_boot_pkg::ST_LINK;
				end else begin
					wait_cnt_nxt = wait_cnt_r + WAIT_CNT_W'(1);
				end
			end
			clock_boot_pkg::ST_LINK: begin
				// Any high receive line counts as boot traffic
				if (i_link_rx != 2'h0) begin
					traffic_nxt = 1'b1;
				end
			end
			clock_boot_pkg::ST_SPI: begin
				// Flash read ends when the loader says so
				if (i_boot_done) begin
					state_nxt = clock_boot_pkg::ST_DONE;
				end
			end
			clock_boot_pkg::ST_OTP,
			clock_boot_pkg::ST_JTAG,
			clock_boot_pkg::ST_IDLE,
			clock_boot_pkg::ST_DONE: begin
				// Terminal: hold until the next reset
				state_nxt = state_r;
			end
		endcase
	end

	// Register sequencer state; reset floats the pins but turns the link pulldown on
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_r            <= clock_boot_pkg::ST_RESET_WAIT;
			wait_cnt_r         <= '0;
			o_gpio_pull_en     <= 1'b0;
			o_boot_from_otp    <= 1'b0;
			o_jtag_wait        <= 1'b0;
			o_link_en          <= 1'b0;
			o_link_pulldown_en <= 1'b1;
			o_link_tx          <= 2'h0;
			o_link_tx_oe       <= 2'h0;
			o_link_traffic     <= 1'b0;
		end else begin
			state_r            <= state_nxt;
			wait_cnt_r         <= wait_cnt_nxt;
			o_gpio_pull_en     <= pull_nxt;
			o_boot_from_otp    <= otp_nxt;
			o_jtag_wait        <= jtag_nxt;
			o_link_en          <= link_en_nxt;
			o_link_pulldown_en <= pd_nxt;
			o_link_tx          <= 2'h0;
			o_link_tx_oe       <= tx_oe_nxt;
			o_link_traffic     <= traffic_nxt;
		end
	end

	assign spi_run = (state_r == clock_boot_pkg::ST_SPI);

	// Half-period ticks for the 2.5 MHz flash clock
	sclk_tick_gen #(
		.HALF_CYC (clock_boot_pkg::SCLK_HALF_CYC),
		.CNT_W    (4)
	) u_sclk_tick (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_run  (spi_run),
		.o_tick (spi_tick)
	);

	// Flash master: send read command, then stream bytes in
	always_comb begin
		sh_out_nxt     = sh_out_r;
		sh_in_nxt      = sh_in_r;
		bit_cnt_nxt    = bit_cnt_r;
		cmd_phase_nxt  = cmd_phase_r;
		sclk_nxt       = o_spi_sclk;
		byte_nxt       = o_boot_byte;
		byte_valid_nxt = 1'b0;
		pins_nxt       = spi_run;
		ss_n_nxt       = !spi_run;
		mosi_nxt       = spi_run ? sh_out_r[31] : 1'b0;
		if (!spi_run) begin
			// Idle: reload the frame, clock low
			sh_out_nxt    = clock_boot_pkg::SPI_READ_FRAME;
			bit_cnt_nxt   = 6'h00;
			cmd_phase_nxt = 1'b1;
			sclk_nxt      = 1'b0;
		end else if (spi_tick) begin
			if (!o_spi_sclk) begin
				// Rising edge: sample the slave data
				sclk_nxt  = 1'b1;
				sh_in_nxt = {sh_in_r[6:0], i_spi_miso};
				if (cmd_phase_r) begin
					if (bit_cnt_r == clock_boot_pkg::SPI_CMD_LAST) begin
						cmd_phase_nxt = 1'b0;
						bit_cnt_nxt   = 6'h00;
					end else begin
						bit_cnt_nxt = bit_cnt_r + 6'h01;
					end
				end else if (bit_cnt_r[2:0] ==
					clock_boot_pkg::SPI_BYTE_LAST) begin
					// Full byte received
					byte_nxt       = {sh_in_r[6:0], i_spi_miso};
					byte_valid_nxt = 1'b1;
					bit_cnt_nxt    = 6'h00;
				end else begin
					bit_cnt_nxt = bit_cnt_r + 6'h01;
				end
			end else begin
				// Falling edge: present the next command bit
				sclk_nxt   = 1'b0;
				sh_out_nxt = {sh_out_r[30:0], 1'b0};
			end
		end
	end

	// Register flash engine state and pins
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			sh_out_r          <= clock_boot_pkg::SPI_READ_FRAME;
			sh_in_r           <= 8'h00;
			bit_cnt_r         <= 6'h00;
			cmd_phase_r       <= 1'b1;
			o_spi_sclk        <= 1'b0;
			o_spi_mosi        <= 1'b0;
			o_spi_ss_n        <= 1'b1;
			o_spi_pins_en     <= 1'b0;
			o_boot_byte       <= 8'h00;
			o_boot_byte_valid <= 1'b0;
		end else begin
			sh_out_r          <= sh_out_nxt;
			sh_in_r           <= sh_in_nxt;
			bit_cnt_r         <= bit_cnt_nxt;
			cmd_phase_r       <= cmd_phase_nxt;
			o_spi_sclk        <= sclk_nxt;
			o_spi_mosi        <= mosi_nxt;
			o_spi_ss_n        <= ss_n_nxt;
			o_spi_pins_en     <= pins_nxt;
			o_boot_byte       <= byte_nxt;
			o_boot_byte_valid <= byte_valid_nxt;
		end
	end
endmodule

// file: verilog/sclk_tick_gen.sv
// Half-period tick generator for the serial flash clock
`timescale 1ns/1ps
module sclk_tick_gen #(
	parameter int HALF_CYC = 2,
	parameter int CNT_W    = 4
)(
	input  wire logic i_mclk,
	input  wire logic i_rst,
	input  wire logic i_run,
	output logic      o_tick
);
	logic [CNT_W-1:0] cnt_r;   // Cycles in this half period
	logic [CNT_W-1:0] cnt_nxt;
	logic             tick_nxt;

	// Count while running, pulse at the end of each half period
	always_comb begin
		cnt_nxt  = '0;
		tick_nxt = 1'b0;
		if (i_run) begin
			if (cnt_r == CNT_W'(HALF_CYC - 1)) begin
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + CNT_W'(1);
			end
		end
	end

	// Register count and tick
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r  <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			o_tick <= tick_nxt;
		end
	end
endmodule
